// ==== scam_defines.vh ====
// Constants for the secure channel management command interpreter.
// Assumes inclusion by bare name from the design files and the bench.
`ifndef SCAM_DEFINES_VH
`define SCAM_DEFINES_VH
// Register byte offsets
`define SCAM_A_CTRL 8'h00
`define SCAM_A_DATA 8'h04
`define SCAM_A_STAT 8'h08
`define SCAM_A_RESP 8'h0C
`define SCAM_A_SESS 8'h10
// Control register fields
`define SCAM_F_GO 16
`define SCAM_F_CLR 17
// Sub-function selectors and block types
`define SCAM_P1_START 8'h03
`define SCAM_P1_TERM 8'h04
`define SCAM_P2_CMD 8'h80
`define SCAM_P2_RSP 8'hA0
// Tags
`define SCAM_T_CMD 8'h73
`define SCAM_T_RSP 8'h53
`define SCAM_T_ALG 8'h89
`define SCAM_T_MSA 8'h88
`define SCAM_T_CSA 8'h8B
`define SCAM_T_MAC 8'h8D
`define SCAM_T_SIZE 8'h8E
// Value lengths
`define SCAM_L_ALG 8'h02
`define SCAM_L_ID 8'h10
`define SCAM_L_TERM 8'h20
// Algorithm bytes: reserved bits b7..b4
`define SCAM_RSV_MASK 8'h78
// Status words
`define SCAM_SW_OK 16'h9000
`define SCAM_SW_MAC 16'h9862
`define SCAM_SW_DATA 16'h6A80
`define SCAM_SW_P1P2 16'h6A86
`define SCAM_SW_FULL 16'h6A84
`define SCAM_SW_COND 16'h6985
`define SCAM_SW_FAIL 16'h6F00
// Reset value and command buffer depth
`define SCAM_SW_RST 16'h0000
`define SCAM_BUF_DEPTH 128
`endif

// ==== scam_alg_dec.v ====
// Decoder for the two algorithm bytes of a channel-start request.
// Assumes bytes held stable by the caller; purely combinational.
module scam_alg_dec (
	// Algorithm bytes
	input wire [7:0] cipher_byte,
	input wire [7:0] integ_byte,
	// Decoded choice
	output wire alg_ok,
	output wire [1:0] cipher_algorithm_select,
	output wire [1:0] integrity_mechanism_select
);
`include "scam_defines.vh"

	// Exactly one bit set
	function onehot8;
		input [7:0] b;
		begin
			onehot8 = (b != 8'h00) && ((b & (b - 8'h01)) == 8'h00);
		end
	endfunction

	// Encode b1/b2/b3/b8 as 0/1/2/3
	function [1:0] enc;
		input [7:0] b;
		begin
			enc = b[7] ? 2'h3 : b[2] ? 2'h2 : b[1] ? 2'h1 : 2'h0;
		end
	endfunction

	// Reserved bits and multi-bit selections are refused
	assign alg_ok = onehot8(cipher_byte) && onehot8(integ_byte) &&
		((cipher_byte & `SCAM_RSV_MASK) == 8'h00) &&
		((integ_byte & `SCAM_RSV_MASK) == 8'h00);
	assign cipher_algorithm_select = enc(cipher_byte);
	assign integrity_mechanism_select = enc(integ_byte);
endmodule

// ==== scam_sess_table.v ====
// Session table: four sessions, each with its endpoint container size.
// Assumes one clock; alloc is a one-cycle pulse.
module scam_sess_table (
	// Clock and reset
	input wire clk,
	input wire rst_n,
	// Allocation
	input wire alloc,
	input wire [15:0] alloc_size,
	input wire clear_all,
	output reg [1:0] free_idx,
	output wire none_free,
	output wire [3:0] valid_map,
	// Lookup for the bulk transfer command
	input wire [1:0] look_idx,
	output wire [15:0] look_size,
	output wire look_valid
);
	reg [15:0] size_q [0:3];
	reg [3:0] val_q;
	integer i;

	// Lowest free entry
	always @* begin
		free_idx = 2'h0;
		for (i = 3; i >= 0; i = i - 1) begin
			if (!val_q[i])
				free_idx = i[1:0];
		end
	end

	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : ent
			// Record size with the session number
			always @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					val_q[g] <= 1'b0;
					size_q[g] <= 16'h0000;
				end else if (clear_all) begin
					val_q[g] <= 1'b0;
				end else if (alloc && free_idx == g && !none_free) begin
					val_q[g] <= 1'b1;
					size_q[g] <= alloc_size;
				end
			end
		end
	endgenerate

	assign none_free = &val_q;
	assign valid_map = val_q;
	assign look_size = size_q[look_idx];
	assign look_valid = val_q[look_idx];
endmodule

// ==== scam_top.v ====
// Command interpreter for channel-start and termination sub-functions,
// reached over AHB-Lite. Assumes an association engine on the same clock
// that checks authentication codes and terminates associations.
`include "scam_defines.vh"

// Notes on behaviour
// - Serve command blocks 80, response blocks A0
// - Start command in tag 73, reply in 53
// - Start needs tags 89, 8B, 8D, 8E
// - Cipher byte: b1,b2,b3,b8 choices; rest reserved
// - Integrity byte: b1,b2,b3,b8 choices; rest reserved
// - Association identifier and auth code 16 bytes
// - Reply byte: session in b8..b7, rest zero
// - Keep session number with container size
// - Termination uses P1 04 and tag 73
// - Failed termination auth code gives 98 62
// - Unknown association termination still succeeds
// - Failure to terminate gives error status
// - Mixed master list may be refused
// - Master TLV: 88, length 32, id, MAC
// - Connection TLV: 8B, length 32, id, MAC
module scam_top (
	// AHB-Lite slave
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output wire hreadyout,
	output wire hresp,
	// Association engine
	output reg sa_query,
	output reg [7:0] sa_kind,
	output reg [6:0] sa_offset,
	input wire sa_done,
	input wire sa_mac_ok,
	input wire sa_exists,
	input wire sa_term_ok,
	// Session lookup for bulk transfers
	input wire [1:0] bulk_sess,
	output wire [15:0] bulk_size,
	output wire bulk_valid
);
	localparam S_IDLE = 8'h01;
	localparam S_HDR = 8'h02;
	localparam S_HLEN = 8'h04;
	localparam S_TAG = 8'h08;
	localparam S_LEN = 8'h10;
	localparam S_VAL = 8'h20;
	localparam S_VER = 8'h40;
	localparam S_FIN = 8'h80;

	reg [7:0] mem [0:`SCAM_BUF_DEPTH-1];
	reg [7:0] st_q;
	reg [7:0] p1_q, p2_q, tag_q, len_q, vcnt_q, end_q;
	reg [7:0] alg1_q, alg2_q, rsp_q;
	reg [6:0] ptr_q, tstart_q;
	reg [7:0] cnt_q;
	reg [15:0] sw_q, size_q;
	reg [3:0] seen_q;
	reg term_q, msa_q, terr_q, clr_q, pend_q;
	reg [1:0] rlen_q, rptr_q;
	reg wr_q;
	reg [7:0] wadr_q;
	wire [7:0] cur_b = mem[ptr_q];
	wire alg_ok, none_free;
	wire [1:0] cip_sel, int_sel, free_idx;
	wire [3:0] vmap;

	////////////////////////////////////////////////////////////////////
	// Bus slave: zero wait states, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	wire aph = hsel & htrans[1] & hready;
	wire busy = ~st_q[0];
	wire wr_ctrl = wr_q && wadr_q == `SCAM_A_CTRL;
	wire go = wr_ctrl && hwdata[`SCAM_F_GO] && !busy;
	wire push = wr_q && wadr_q == `SCAM_A_DATA && !busy &&
		cnt_q < `SCAM_BUF_DEPTH;
	wire pop = aph && !hwrite && haddr[7:0] == `SCAM_A_RESP &&
		rptr_q < rlen_q;

	// Response byte at the read pointer
	function [7:0] rbyte;
		input [1:0] idx;
		input [7:0] sb;
		begin
			case (idx)
				2'h0: rbyte = `SCAM_T_RSP;
				2'h1: rbyte = 8'h01;
				default: rbyte = sb;
			endcase
		end
	endfunction

	// Address phase capture and read data, latched for the data phase
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'b0;
			wadr_q <= 8'h00;
			hrdata <= 32'h00000000;
			rptr_q <= 2'h0;
		end else begin
			wr_q <= aph & hwrite;
			wadr_q <= haddr[7:0];
			if (go)
				rptr_q <= 2'h0;
			else if (pop)
				rptr_q <= rptr_q + 2'h1;
			if (aph && !hwrite) begin
				case (haddr[7:0])
					`SCAM_A_CTRL: hrdata <= {16'h0000, p2_q, p1_q};
					`SCAM_A_STAT: hrdata <= {4'h0, rlen_q - rptr_q, pend_q,
						busy, cnt_q[7:0], sw_q};
					`SCAM_A_RESP: hrdata <= {24'h000000, pop ?
						rbyte(rptr_q, rsp_q) : 8'h00};
					`SCAM_A_SESS: hrdata <= {20'h00000, cip_sel, int_sel,
						4'h0, vmap};
					default: hrdata <= 32'h00000000;
				endcase
			end
		end
	end

	// Command buffer fill
	always @(posedge hclk) begin
		if (push)
			mem[cnt_q[6:0]] <= hwdata[7:0];
	end

	////////////////////////////////////////////////////////////////////
	// Checks on a finished TLV; mixed master lists are refused
	wire st_mode = ~term_q;
	wire bad_start = (tag_q == `SCAM_T_ALG && len_q != `SCAM_L_ALG) ||
		((tag_q == `SCAM_T_CSA || tag_q == `SCAM_T_MAC) &&
		len_q != `SCAM_L_ID) ||
		(tag_q == `SCAM_T_SIZE && len_q > 8'h02) ||
		(tag_q != `SCAM_T_ALG && tag_q != `SCAM_T_CSA &&
		tag_q != `SCAM_T_MAC && tag_q != `SCAM_T_SIZE);
	wire bad_term = len_q != `SCAM_L_TERM || msa_q ||
		(tag_q == `SCAM_T_MSA && seen_q != 4'h0) ||
		(tag_q != `SCAM_T_MSA && tag_q != `SCAM_T_CSA);
	wire need_ver = term_q || tag_q == `SCAM_T_MAC;
	wire last_b = vcnt_q == len_q - 8'h01;
	wire fits = {2'b00, ptr_q} + 9'h001 + {1'b0, cur_b} <= {1'b0, end_q};
	wire start_ok = seen_q == 4'hF && alg_ok;
	wire do_alloc = st_q == S_FIN && st_mode && start_ok && !none_free;

	////////////////////////////////////////////////////////////////////
	// Interpreter state machine
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q <= S_IDLE;
			p1_q <= 8'h00;
			p2_q <= 8'h00;
			tag_q <= 8'h00;
			len_q <= 8'h00;
			vcnt_q <= 8'h00;
			end_q <= 8'h00;
			alg1_q <= 8'h00;
			alg2_q <= 8'h00;
			rsp_q <= 8'h00;
			ptr_q <= 7'h00;
			tstart_q <= 7'h00;
			cnt_q <= 8'h00;
			sw_q <= `SCAM_SW_RST;
			size_q <= 16'h0000;
			seen_q <= 4'h0;
			term_q <= 1'b0;
			msa_q <= 1'b0;
			terr_q <= 1'b0;
			clr_q <= 1'b0;
			pend_q <= 1'b0;
			rlen_q <= 2'h0;
			sa_query <= 1'b0;
			sa_kind <= 8'h00;
			sa_offset <= 7'h00;
		end else begin
			sa_query <= 1'b0;
			clr_q <= 1'b0;
			if (push)
				cnt_q <= cnt_q + 8'h01;
			case (st_q)
				S_IDLE: begin
					if (wr_ctrl && !hwdata[`SCAM_F_GO] && hwdata[`SCAM_F_CLR])
						cnt_q <= 8'h00;
					if (wr_ctrl) begin
						p1_q <= hwdata[7:0];
						p2_q <= hwdata[15:8];
					end
					if (go) begin
						rlen_q <= 2'h0;
						if (hwdata[7:0] != `SCAM_P1_START &&
							hwdata[7:0] != `SCAM_P1_TERM) begin
							sw_q <= `SCAM_SW_P1P2;
						end else if (hwdata[15:8] == `SCAM_P2_CMD) begin
							term_q <= hwdata[7:0] == `SCAM_P1_TERM;
							ptr_q <= 7'h00;
							seen_q <= 4'h0;
							msa_q <= 1'b0;
							terr_q <= 1'b0;
							size_q <= 16'h0000;
							st_q <= S_HDR;
						end else if (hwdata[15:8] == `SCAM_P2_RSP) begin
							if (hwdata[7:0] == `SCAM_P1_TERM) begin
								sw_q <= `SCAM_SW_OK;
							end else if (pend_q) begin
								rlen_q <= 2'h3;
								pend_q <= 1'b0;
								sw_q <= `SCAM_SW_OK;
							end else begin
								sw_q <= `SCAM_SW_COND;
							end
						end else begin
							sw_q <= `SCAM_SW_P1P2;
						end
					end
				end
				S_HDR: begin
					ptr_q <= 7'h01;
					if (cnt_q < 8'h02 || cur_b != `SCAM_T_CMD) begin
						sw_q <= `SCAM_SW_DATA;
						st_q <= S_IDLE;
					end else begin
						st_q <= S_HLEN;
					end
				end
				S_HLEN: begin
					end_q <= cur_b + 8'h02;
					ptr_q <= 7'h02;
					if ({1'b0, cur_b} + 9'h002 > {1'b0, cnt_q}) begin
						sw_q <= `SCAM_SW_DATA;
						st_q <= S_IDLE;
					end else begin
						st_q <= S_TAG;
					end
				end
				S_TAG: begin
					if ({1'b0, ptr_q} >= end_q) begin
						st_q <= S_FIN;
					end else begin
						tag_q <= cur_b;
						tstart_q <= ptr_q;
						ptr_q <= ptr_q + 7'h01;
						st_q <= S_LEN;
					end
				end
				S_LEN: begin
					len_q <= cur_b;
					vcnt_q <= 8'h00;
					ptr_q <= ptr_q + 7'h01;
					if (cur_b == 8'h00 || !fits) begin
						sw_q <= `SCAM_SW_DATA;
						st_q <= S_IDLE;
					end else begin
						st_q <= S_VAL;
					end
				end
				S_VAL: begin
					ptr_q <= ptr_q + 7'h01;
					vcnt_q <= vcnt_q + 8'h01;
					if (tag_q == `SCAM_T_ALG && vcnt_q == 8'h00)
						alg1_q <= cur_b;
					if (tag_q == `SCAM_T_ALG && vcnt_q == 8'h01)
						alg2_q <= cur_b;
					if (st_mode && tag_q == `SCAM_T_SIZE)
						size_q <= {size_q[7:0], cur_b};
					if (last_b) begin
						if (st_mode ? bad_start : bad_term) begin
							sw_q <= `SCAM_SW_DATA;
							st_q <= S_IDLE;
						end else begin
							seen_q <= seen_q | (term_q ? 4'h1 : {
								tag_q == `SCAM_T_SIZE, tag_q == `SCAM_T_MAC,
								tag_q == `SCAM_T_CSA, tag_q == `SCAM_T_ALG});
							msa_q <= term_q && tag_q == `SCAM_T_MSA;
							sa_query <= need_ver;
							sa_kind <= tag_q;
							sa_offset <= tstart_q;
							st_q <= need_ver ? S_VER : S_TAG;
						end
					end
				end
				S_VER: begin
					if (sa_done) begin
						if (!sa_mac_ok) begin
							sw_q <= `SCAM_SW_MAC;
							st_q <= S_IDLE;
						end else begin
							// Unknown association counts as done
							if (term_q && sa_exists && !sa_term_ok)
								terr_q <= 1'b1;
							if (term_q && msa_q && sa_exists && sa_term_ok)
								clr_q <= 1'b1;
							st_q <= S_TAG;
						end
					end
				end
				S_FIN: begin
					st_q <= S_IDLE;
					if (term_q) begin
						sw_q <= terr_q ? `SCAM_SW_FAIL : `SCAM_SW_OK;
					end else if (!start_ok) begin
						sw_q <= `SCAM_SW_DATA;
					end else if (none_free) begin
						sw_q <= `SCAM_SW_FULL;
					end else begin
						rsp_q <= {free_idx, 6'h00};
						pend_q <= 1'b1;
						sw_q <= `SCAM_SW_OK;
					end
				end
				default: st_q <= S_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Algorithm decode and session table
	scam_alg_dec u_alg (.cipher_byte(alg1_q), .integ_byte(alg2_q), .alg_ok(alg_ok),
		.cipher_algorithm_select(cip_sel), .integrity_mechanism_select(int_sel));

	scam_sess_table u_sess (.clk(hclk), .rst_n(hresetn), .alloc(do_alloc),
		.alloc_size(size_q), .clear_all(clr_q), .free_idx(free_idx), .none_free(none_free),
		.valid_map(vmap), .look_idx(bulk_sess), .look_size(bulk_size),
		.look_valid(bulk_valid));
endmodule

// ==== scam_props.sv ====
// Checker for the secure channel command interpreter, top ports only.
// Assumes one clock domain and a zero wait state bus slave.
module scam_props (
	// Bus
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire hready,
	input wire [31:0] hrdata,
	input wire hreadyout,
	input wire hresp,
	// Engine and session lookup
	input wire sa_query,
	input wire [7:0] sa_kind,
	input wire [6:0] sa_offset,
	input wire bulk_valid
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	////////////////////////////////////////
	// Query for one TLV kind
	sequence s_query(k);
		sa_query && sa_kind == k;
	endsequence
	// Bus answer and read data
	a_ready_high: assert property (hreadyout)
		else $error("bus slave stalled");
	a_resp_okay: assert property (!hresp)
		else $error("bus slave gave an error response");
	a_rdata_hold: assert property (!(hsel && htrans[1] && !hwrite && hready)
		|=> $stable(hrdata))
		else $error("read data changed without a read");
	// Engine queries
	a_query_pulse: assert property (sa_query |=> !sa_query)
		else $error("engine query longer than one cycle");
	a_query_kind: assert property (sa_query |-> sa_kind inside {8'h8D, 8'h88, 8'h8B})
		else $error("engine query for an unknown tag");
	a_master_offset: assert property (s_query(8'h88) |-> sa_offset == 7'd2)
		else $error("master association not first and alone");
	a_conn_offset: assert property (s_query(8'h8B)
		|-> (sa_offset - 7'd2) % 7'd34 == 7'd0)
		else $error("connection association off the 34 byte grid");
	// No session survives a reset
	a_bulk_reset: assert property ($rose(hresetn) |-> !bulk_valid)
		else $error("session valid right after reset");
endmodule

bind scam_top scam_props i_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.sa_query(sa_query), .sa_kind(sa_kind), .sa_offset(sa_offset), .bulk_valid(bulk_valid));

// ==== scam_engine_model.sv ====
// Association engine model answering the interpreter's TLV checks.
// Assumes the bench sets the verdict before a command starts.
module scam_engine_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Verdict chosen by the bench
	input wire logic slow,
	input wire logic mac_ok,
	input wire logic exists,
	input wire logic term_ok,
	// Interpreter side
	input wire logic sa_query,
	output logic sa_done,
	output logic sa_mac_ok,
	output logic sa_exists,
	output logic sa_term_ok
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] wait_q;
	logic busy_q;
	// Answer promptly or after ten idle cycles, one pulse of done
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			busy_q <= 1'b0;
			wait_q <= 4'h0;
			sa_done <= 1'b0;
		end else begin
			sa_done <= 1'b0;
			if (sa_query) begin
				busy_q <= 1'b1;
				wait_q <= slow ? 4'hA : 4'h0;
			end else if (busy_q && wait_q != 4'h0) begin
				wait_q <= wait_q - 4'h1;
			end else if (busy_q) begin
				busy_q <= 1'b0;
				sa_done <= 1'b1;
			end
		end
	end
	// Verdict only beside done, the inverse otherwise
	assign sa_mac_ok = sa_done ? mac_ok : !mac_ok;
	assign sa_exists = sa_done ? exists : !exists;
	assign sa_term_ok = sa_done ? term_ok : !term_ok;
endmodule

// ==== tb_secure_channel_assoc_cmd.sv ====
// Bench for the interpreter: bus tasks, start and terminate sequences.
// Assumes the engine model and the checker are compiled alongside.
`include "scam_defines.vh"
module tb_secure_channel_assoc_cmd;
	timeunit 1ns;
	timeprecision 1ns;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
	logic slow = 0, mac_ok = 1, exists = 1, term_ok = 1;
	logic [1:0] htrans = 0, bulk_sess = 0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] haddr = 0, hwdata = 0, rd;
	logic [7:0] alg [4] = '{8'h01, 8'h02, 8'h04, 8'h80};
	logic [2:0] cfg [4] = '{3'b011, 3'b100, 3'b110, 3'b111};
	logic [15:0] swt [4] = '{`SCAM_SW_MAC, `SCAM_SW_OK, `SCAM_SW_FAIL, `SCAM_SW_OK};
	wire [31:0] hrdata;
	wire [15:0] bulk_size;
	wire [7:0] sa_kind;
	wire [6:0] sa_offset;
	wire hreadyout, hresp, sa_query, sa_done, sa_mac_ok, sa_exists, sa_term_ok, bulk_valid;
	int miscompares = 0, check_count = 0;
	always #5 hclk = ~hclk;
	////////////////////////////////////////
	scam_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .sa_query(sa_query), .sa_kind(sa_kind),
		.sa_offset(sa_offset), .sa_done(sa_done), .sa_mac_ok(sa_mac_ok), .sa_exists(sa_exists),
		.sa_term_ok(sa_term_ok), .bulk_sess(bulk_sess), .bulk_size(bulk_size),
		.bulk_valid(bulk_valid));
	scam_engine_model i_eng (.clk(hclk), .rst_n(hresetn), .slow(slow), .mac_ok(mac_ok),
		.exists(exists), .term_ok(term_ok), .sa_query(sa_query), .sa_done(sa_done),
		.sa_mac_ok(sa_mac_ok), .sa_exists(sa_exists), .sa_term_ok(sa_term_ok));
	// Compare and count
	task chk(input [31:0] seen, input [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t ns: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task results;
		$display("checks %0d, mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// One single transfer: address phase, then data phase
	task bus(input w, input [7:0] a, input [31:0] d);
		hsel <= 1'b1;
		hwrite <= w;
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task ld(input [7:0] b);
		bus(1, 8'h04, {24'h0, b});
	endtask
	// Execute with P2 and P1, then wait for busy to drop
	task go(input [15:0] pp);
		bus(1, 8'h00, {16'h0001, pp});
		do bus(0, 8'h08, 0); while (rd[24] !== 1'b0);
	endtask
	task stat(input [15:0] sw);
		bus(0, 8'h08, 0);
		chk(rd[15:0], sw);
	endtask
	task start(input [7:0] c, input [7:0] i, input [7:0] sz);
		bus(1, 8'h00, 32'h20000);
		ld(8'h73);
		ld(8'h2B);
		ld(8'h89);
		ld(8'h02);
		ld(c);
		ld(i);
		ld(8'h8B);
		ld(8'h10);
		repeat (16) ld(8'hA5);
		ld(8'h8D);
		ld(8'h10);
		repeat (16) ld(8'h5A);
		ld(8'h8E);
		ld(8'h01);
		ld(sz);
		go(16'h8003);
	endtask
	task term(input [7:0] k, input int n);
		bus(1, 8'h00, 32'h20000);
		ld(8'h73);
		ld(8'(34 * n));
		repeat (n) begin
			ld(k);
			ld(8'h20);
			repeat (32) ld(8'h3C);
		end
		go(16'h8004);
	endtask
	////////////////////////////////////////
	// Hang guard, far beyond the few thousand cycles the tests need
	initial begin
		#200000;
		miscompares++;
		results;
	end
	// Main sequence
	initial begin
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(0, 8'h40, 0);
		chk(rd, 0);
		go(16'h0003);
		stat(`SCAM_SW_P1P2);
		start(8'h10, 8'h01, 8'h20);
		stat(`SCAM_SW_DATA);
		start(8'h01, 8'h03, 8'h20);
		stat(`SCAM_SW_DATA);
		// Every cipher and integrity choice, one session each
		for (int s = 0; s < 4; s++) begin
			start(alg[s], alg[3 - s], 8'(s + 5));
			stat(`SCAM_SW_OK);
			bus(0, 8'h10, 0);
			chk(rd[11:8], {2'(s), 2'(3 - s)});
			go(16'hA003);
			bus(0, 8'h0C, 0);
			chk(rd, 32'h53);
			bus(0, 8'h0C, 0);
			chk(rd, 32'h01);
			bus(0, 8'h0C, 0);
			chk(rd, {24'h0, 2'(s), 6'h0});
			bulk_sess <= 2'(s);
			@(posedge hclk);
			chk({bulk_valid, bulk_size}, {1'b1, 16'(s + 5)});
		end
		// All four sessions taken: a fifth start is refused, nothing to fetch
		start(8'h01, 8'h01, 8'h09);
		stat(`SCAM_SW_FULL);
		go(16'hA003);
		stat(`SCAM_SW_COND);
		// Termination verdicts: bad code, unknown, refused, done
		for (int t = 0; t < 4; t++) begin
			{mac_ok, exists, term_ok} <= cfg[t];
			slow <= t[0];
			term(t == 3 ? 8'h88 : 8'h8B, t == 3 ? 1 : 2);
			stat(swt[t]);
		end
		// Master termination leaves no session behind
		bus(0, 8'h10, 0);
		chk({bulk_valid, rd[3:0]}, 5'h00);
		go(16'hA004);
		stat(`SCAM_SW_OK);
		bus(0, 8'h0C, 0);
		chk(rd, 0);
		results;
	end
endmodule
